// [rsx_pkg.sv]
// Package of encodings, field positions and timing counts for the execute slice
// ****************************************************************************
// Function
// - A non-blocking stream write, or a blocking one with link space, completes in two cycles.
// - A blocking stream write holds the pipeline while the outgoing link has no space.
// - Register reverse subtract adds operand_b to the inverse of source_a and writes the destination.
// - Instruction bit 3 set keeps the carry flag, cleared loads it from the adder carry-out.
// - With bit 3 cleared both register and immediate forms update carry from the carry-out.
// - Instruction bit 4 set uses the carry flag as carry-in, cleared forces carry-in to one.
// - After a subtraction carry set means no borrow and carry clear means a borrow.
// - Immediate reverse subtract computes the extended immediate minus source_a with the same options.
// - The 16-bit immediate is sign-extended unless a directly preceding prefix supplies the upper half.
// - Return from break branches to source_a plus immediate and then clears break_in_progress.
// - Return from break executes one delay slot with breaks still disabled.
// - Return from interrupt branches to source_a plus immediate and then sets interrupt_enable_flag.
// - Return from interrupt executes one delay slot with interrupts still disabled.
// - Return from subroutine branches to source_a plus immediate, touches no flag, with a delay slot.
// - Register byte store writes data bits 0 to 7 to the unmasked sum of the two sources.
// - Immediate byte store writes the low data byte to source_a plus the extended immediate.
// ****************************************************************************
package rsx_pkg;
  localparam logic [5:0] OP_RSUB = 6'h01;
  localparam logic [5:0] OP_RSUBI = 6'h09;
  localparam logic [5:0] OP_IMM = 6'h2c;
  localparam logic [5:0] OP_RET = 6'h2d;
  localparam logic [5:0] OP_SB = 6'h34;
  localparam logic [5:0] OP_SBI = 6'h3c;
  localparam logic [5:0] OP_PUT = 6'h1b;
  localparam logic [4:0] RET_SUB = 5'h10;
  localparam logic [4:0] RET_INT = 5'h11;
  localparam logic [4:0] RET_BRK = 5'h12;
  localparam int BIT_KEEP = 3;
  localparam int BIT_CIN = 4;
  localparam int BIT_NBLK = 16;
  localparam int BIT_CTRL = 17;
  localparam int PUT_CYCLES = 2;
  localparam int STORE_CYCLES = 2;
  typedef enum logic [1:0] {
    RSX_IDLE = 2'b00,
    RSX_FINISH = 2'b01,
    RSX_STALL = 2'b11
  } rsx_state_t;
endpackage

// [rsx_alu.sv]
// Reverse-subtract adder with carry selection
`timescale 1ns/1ps
`default_nettype none
module rsx_alu #(
  parameter int W = 32
) (
  input wire logic [W-1:0] i_minuend,
  input wire logic [W-1:0] i_subtrahend,
  input wire logic i_use_carry,
  input wire logic i_carry,
  output logic [W-1:0] o_diff,
  output logic o_carry_out
);
  logic cin;
  logic [W:0] sum;
  // ****************************************************************************
  // Adder
  // ****************************************************************************
  // Carry-in is one for plain subtraction, the flag when chained
  assign cin = i_use_carry ? i_carry : 1'b1;
  // Inverse of subtrahend plus minuend; top bit is not-borrow
  assign sum = {1'b0, i_minuend} + {1'b0, ~i_subtrahend} + {{W{1'b0}}, cin};
  assign o_diff = sum[W-1:0];
  assign o_carry_out = sum[W];
endmodule
`default_nettype wire

// [rsx_exec.sv]
// Execute slice: reverse subtract, returns, byte stores and stream write
`timescale 1ns/1ps
`default_nettype none
module rsx_exec #(
  parameter int W = 32
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_valid,
  input wire logic [31:0] i_instr,
  input wire logic [W-1:0] i_source_a,
  input wire logic [W-1:0] i_operand_b,
  input wire logic [W-1:0] i_data,
  input wire logic i_link_full,
  output logic o_busy,
  output logic o_wr_en,
  output logic [4:0] o_wr_addr,
  output logic [W-1:0] o_wr_data,
  output logic o_branch,
  output logic [W-1:0] o_branch_target,
  output logic o_carry,
  output logic o_break_in_progress,
  output logic o_interrupt_enable_flag,
  output logic o_delay_slot,
  output logic o_mem_we,
  output logic [W-1:0] o_mem_addr,
  output logic [7:0] o_mem_byte,
  output logic o_link_valid,
  output logic [W-1:0] o_link_data,
  output logic o_link_ctrl
);
  typedef struct packed {
    rsx_pkg::rsx_state_t st;
    logic [15:0] hi;
    logic hi_valid;
    logic carry;
    logic break_in_progress;
    logic ie;
    logic slot;
    logic [1:0] ret_kind;
    logic wr_en;
    logic [4:0] wr_addr;
    logic [W-1:0] wr_data;
    logic branch;
    logic [W-1:0] target;
    logic mem_we;
    logic [W-1:0] mem_addr;
    logic [7:0] mem_byte;
    logic link_valid;
    logic [W-1:0] link_data;
    logic link_ctrl;
  } rsx_regs_t;

  rsx_regs_t s_reg;
  rsx_regs_t s_next;
  logic [5:0] opc;
  logic [4:0] rd;
  logic [W-1:0] imm_ext;
  logic [W-1:0] alu_min;
  logic [W-1:0] diff;
  logic cout;
  logic is_put;
  logic put_blocks;
  logic is_rsub;

  // ****************************************************************************
  // Decode
  // ****************************************************************************
  assign opc = i_instr[31:26];
  assign rd = i_instr[25:21];
  // Prefix supplies the upper half, otherwise sign extension
  assign imm_ext = s_reg.hi_valid ? {s_reg.hi, i_instr[15:0]} : {{16{i_instr[15]}}, i_instr[15:0]};
  // Bits 3 and 4 of the instruction sit at positions 28 and 27 here
  assign alu_min = (opc[5:3] == 3'b001) ? imm_ext : i_operand_b;
  // Both forms and all keep and carry variants; K and C sit inside the opcode
  assign is_rsub = (opc[5:4] == 2'b00) && opc[0];
  assign is_put = i_valid && (opc == rsx_pkg::OP_PUT);
  // Blocking write must wait while the link is full
  assign put_blocks = is_put && !i_instr[rsx_pkg::BIT_NBLK] && i_link_full;

  rsx_alu #(
    .W(W)
  ) u_alu (
    .i_minuend(alu_min),
    .i_subtrahend(i_source_a),
    .i_use_carry(i_instr[31 - rsx_pkg::BIT_CIN]),
    .i_carry(s_reg.carry),
    .o_diff(diff),
    .o_carry_out(cout)
  );

  // ****************************************************************************
  // Next state
  // ****************************************************************************
  // One-cycle pulses cleared each cycle; flags change only on their events
  always_comb
  begin
    s_next = s_reg;
    s_next.wr_en = 1'b0;
    s_next.branch = 1'b0;
    s_next.mem_we = 1'b0;
    s_next.link_valid = 1'b0;
    s_next.slot = 1'b0;
    // Flag side effect lands after the delay slot has run
    if (s_reg.slot)
    begin
      if (s_reg.ret_kind == 2'd2)
        s_next.break_in_progress = 1'b0;
      if (s_reg.ret_kind == 2'd1)
        s_next.ie = 1'b1;
    end
    case (s_reg.st)
      rsx_pkg::RSX_FINISH:
      begin
        s_next.st = rsx_pkg::RSX_IDLE;
      end
      rsx_pkg::RSX_STALL:
      begin
        if (!i_link_full)
        begin
          s_next.link_valid = 1'b1;
          s_next.link_data = i_source_a;
          s_next.link_ctrl = i_instr[rsx_pkg::BIT_CTRL];
          s_next.st = rsx_pkg::RSX_FINISH;
        end
      end
      default:
      begin
        if (i_valid)
        begin
          s_next.hi_valid = 1'b0;
          if (opc == rsx_pkg::OP_IMM)
          begin
            s_next.hi = i_instr[15:0];
            s_next.hi_valid = 1'b1;
          end
          else if (is_rsub)
          begin
            // Group covers keep and carry variants of both forms
            s_next.wr_en = 1'b1;
            s_next.wr_addr = rd;
            s_next.wr_data = diff;
          end
          else if (opc == rsx_pkg::OP_RET)
          begin
            s_next.branch = 1'b1;
            s_next.target = i_source_a + imm_ext;
            s_next.slot = 1'b1;
            s_next.ret_kind = (rd == rsx_pkg::RET_BRK) ? 2'd2 : (rd == rsx_pkg::RET_INT) ? 2'd1 : 2'd0;
          end
          else if (opc == rsx_pkg::OP_SB)
          begin
            s_next.mem_we = 1'b1;
            s_next.mem_addr = i_source_a + i_operand_b;
            s_next.mem_byte = i_data[7:0];
            s_next.st = rsx_pkg::RSX_FINISH;
          end
          else if (opc == rsx_pkg::OP_SBI)
          begin
            s_next.mem_we = 1'b1;
            s_next.mem_addr = i_source_a + imm_ext;
            s_next.mem_byte = i_data[7:0];
            s_next.st = rsx_pkg::RSX_FINISH;
          end
          else if (is_put)
          begin
            if (put_blocks)
              s_next.st = rsx_pkg::RSX_STALL;
            else
            begin
              s_next.link_valid = !i_link_full;
              s_next.link_data = i_source_a;
              s_next.link_ctrl = i_instr[rsx_pkg::BIT_CTRL];
              s_next.st = rsx_pkg::RSX_FINISH;
              // Non-blocking write reports a full link through carry
              s_next.carry = i_link_full;
            end
          end
          // Carry update for subtraction unless keep is set
          if (is_rsub && !i_instr[31 - rsx_pkg::BIT_KEEP])
            s_next.carry = cout;
        end
      end
    endcase
    if (!i_rst_n)
    begin
      s_next = '0;
      s_next.st = rsx_pkg::RSX_IDLE;
    end
  end

  // ****************************************************************************
  // State register
  // ****************************************************************************
  always_ff @(posedge i_ref_clk)
  begin
    s_reg <= s_next;
  end

  // ****************************************************************************
  // Outputs
  // ****************************************************************************
  // Busy holds the issuing stage; handshake may be combinational
  assign o_busy = (s_reg.st == rsx_pkg::RSX_STALL) || (s_reg.st == rsx_pkg::RSX_FINISH) || put_blocks;
  assign o_wr_en = s_reg.wr_en;
  assign o_wr_addr = s_reg.wr_addr;
  assign o_wr_data = s_reg.wr_data;
  assign o_branch = s_reg.branch;
  assign o_branch_target = s_reg.target;
  assign o_carry = s_reg.carry;
  assign o_break_in_progress = s_reg.break_in_progress;
  assign o_interrupt_enable_flag = s_reg.ie;
  assign o_delay_slot = s_reg.slot;
  assign o_mem_we = s_reg.mem_we;
  assign o_mem_addr = s_reg.mem_addr;
  assign o_mem_byte = s_reg.mem_byte;
  assign o_link_valid = s_reg.link_valid;
  assign o_link_data = s_reg.link_data;
  assign o_link_ctrl = s_reg.link_ctrl;

  // ****************************************************************************
  // Checks
  // ****************************************************************************
  // Accepted write finishes in exactly two cycles
  property p_put_two;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && is_put && !put_blocks) |=> (s_reg.st == rsx_pkg::RSX_FINISH) ##1 (s_reg.st == rsx_pkg::RSX_IDLE);
  endproperty
  a_put_two: assert property (p_put_two) else $error("stream write not two cycles");
  // Nothing leaves on the link while a blocking write is stalled
  property p_put_stall;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_STALL && i_link_full) |-> o_busy ##1 !o_link_valid;
  endproperty
  a_put_stall: assert property (p_put_stall) else $error("blocking write leaked while full");
  // Register form result against the carry-in rule
  property p_sub;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && is_rsub && !opc[3])
      |=> o_wr_en && o_wr_data == $past(i_operand_b) - $past(i_source_a) - {{(W-1){1'b0}}, $past(i_instr[27]) & ~$past(s_reg.carry)};
  endproperty
  a_sub: assert property (p_sub) else $error("reverse subtract wrong");
  // Keep variants of both forms leave carry alone
  property p_keep;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && is_rsub && i_instr[28]) |=> $stable(o_carry);
  endproperty
  a_keep: assert property (p_keep) else $error("keep carry lost");
  // Plain immediate subtract: carry set exactly when no borrow
  property p_borrow;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && is_rsub && opc[3] && i_instr[28:27] == 2'b00)
      |=> o_carry == ($past(imm_ext) >= $past(i_source_a));
  endproperty
  a_borrow: assert property (p_borrow) else $error("carry not inverse borrow");
  // Break flag untouched in the slot, clear afterwards
  property p_brk;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_branch && s_reg.ret_kind == 2'd2) |-> $stable(o_break_in_progress) ##1 !o_break_in_progress;
  endproperty
  a_brk: assert property (p_brk) else $error("break flag timing wrong");
  // Interrupt enable unchanged in the slot, then comes on
  property p_int;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_branch && s_reg.ret_kind == 2'd1) |-> $stable(o_interrupt_enable_flag) ##1 o_interrupt_enable_flag;
  endproperty
  a_int: assert property (p_int) else $error("interrupt enable timing wrong");
  property p_sb;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && opc == rsx_pkg::OP_SB)
      |=> o_mem_we && o_mem_addr == $past(i_source_a) + $past(i_operand_b) && o_mem_byte == $past(i_data[7:0]);
  endproperty
  a_sb: assert property (p_sb) else $error("byte store wrong");

  // Refused non-blocking write leaves the link idle and flags carry
  property p_put_refused;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && is_put && i_instr[rsx_pkg::BIT_NBLK] && i_link_full) |=> !o_link_valid && o_carry;
  endproperty
  a_put_refused: assert property (p_put_refused) else $error("refused write not flagged");

  // Non-blocking write with space goes out and clears carry
  property p_put_sent;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && is_put && i_instr[rsx_pkg::BIT_NBLK] && !i_link_full) |=> o_link_valid && !o_carry;
  endproperty
  a_put_sent: assert property (p_put_sent) else $error("accepted write not sent");

  // Stalled word leaves one cycle after space appears
  property p_stall_release;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_STALL && !i_link_full) |=> o_link_valid && o_link_data == $past(i_source_a);
  endproperty
  a_stall_release: assert property (p_stall_release) else $error("stalled word not released");

  // Chained variants use the flag as carry-in
  property p_carry_in;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && is_rsub && i_instr[31 - rsx_pkg::BIT_CIN])
      |=> o_wr_data == $past(alu_min) + ~$past(i_source_a) + {{(W-1){1'b0}}, $past(s_reg.carry)};
  endproperty
  a_carry_in: assert property (p_carry_in) else $error("carry-in not used");

  // Prefix supplies the upper half of the immediate
  property p_imm_prefix;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && s_reg.hi_valid && opc == rsx_pkg::OP_SBI)
      |=> o_mem_addr == $past(i_source_a) + {$past(s_reg.hi), $past(i_instr[15:0])};
  endproperty
  a_imm_prefix: assert property (p_imm_prefix) else $error("prefixed immediate wrong");

  // Without prefix the immediate store address is sign extended
  property p_imm_sext;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && !s_reg.hi_valid && opc == rsx_pkg::OP_SBI)
      |=> o_mem_addr == $past(i_source_a) + {{16{$past(i_instr[15])}}, $past(i_instr[15:0])};
  endproperty
  a_imm_sext: assert property (p_imm_sext) else $error("immediate store address wrong");

  // Every return branches with a slot to source plus immediate
  property p_ret_target;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && !s_reg.hi_valid && opc == rsx_pkg::OP_RET)
      |=> o_branch && o_delay_slot && o_branch_target == $past(i_source_a) + {{16{$past(i_instr[15])}}, $past(i_instr[15:0])};
  endproperty
  a_ret_target: assert property (p_ret_target) else $error("return target wrong");

  // Subroutine return changes no status flag
  property p_rts_flags;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_branch && s_reg.ret_kind == 2'd0) |=> $stable(o_interrupt_enable_flag) && $stable(o_break_in_progress);
  endproperty
  a_rts_flags: assert property (p_rts_flags) else $error("subroutine return touched a flag");

  // Stores take two cycles and write no register
  property p_store_hold;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    (s_reg.st == rsx_pkg::RSX_IDLE && i_valid && (opc == rsx_pkg::OP_SB || opc == rsx_pkg::OP_SBI)) |=> o_busy && !o_wr_en;
  endproperty
  a_store_hold: assert property (p_store_hold) else $error("store timing wrong");

  // A delay slot only ever follows a return branch
  property p_slot_pulse;
    @(posedge i_ref_clk) disable iff (!i_rst_n)
    o_delay_slot |-> o_branch;
  endproperty
  a_slot_pulse: assert property (p_slot_pulse) else $error("slot without branch");

  c_stall: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) s_reg.st == rsx_pkg::RSX_STALL ##1 o_link_valid);
  c_rtbd: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_branch && s_reg.ret_kind == 2'd2);
  c_sb: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_mem_we);
  c_prefix: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) s_reg.hi_valid && i_valid && opc == rsx_pkg::OP_SBI);
  c_refused: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) is_put && i_instr[rsx_pkg::BIT_NBLK] && i_link_full);
endmodule
`default_nettype wire

// [rsx_far_model.sv]
// Far-side model: data memory byte port and outgoing stream link
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Memory and link model
// ****************************************
module rsx_far_model (
  input wire logic i_ref_clk,
  input wire logic i_hold,
  input wire logic i_mem_we,
  input wire logic [7:0] i_mem_byte,
  input wire logic i_link_valid,
  input wire logic [31:0] i_link_data,
  output logic o_link_full,
  output logic [7:0] o_last_byte,
  output logic [31:0] o_last_word
);
  // Link reports no space only while a scenario commands a stall
  assign o_link_full = i_hold;
  // Capture each stored byte and each word taken from the link
  always @(posedge i_ref_clk)
  begin
    if (i_mem_we)
      o_last_byte <= i_mem_byte;
    if (i_link_valid && !i_hold)
      o_last_word <= i_link_data;
  end
endmodule
`default_nettype wire

// [rsx_exec_tb_top.sv]
// Self-checking testbench for the execute slice
`timescale 1ns/1ps
`default_nettype none
module rsx_exec_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0;
  logic hold = 1'b0;
  logic [31:0] instr = 32'h0;
  logic [31:0] a = 32'h0;
  logic [31:0] b = 32'h0;
  logic [31:0] d = 32'h0;
  logic full, busy, wr_en, branch, carry, break_in_progress, ie, slot, mem_we, lvalid, lctrl;
  logic [4:0] wr_addr;
  logic [31:0] wr_data, tgt, maddr, ldata, last_word;
  logic [7:0] mbyte, last_byte;
  int n_mismatch = 0;
  int checks = 0;
  // 25 MHz reference clock
  always #20 clk = ~clk;
  rsx_exec u_rsx_exec (.i_ref_clk(clk), .i_rst_n(rst_n), .i_valid(valid), .i_instr(instr),
    .i_source_a(a), .i_operand_b(b), .i_data(d), .i_link_full(full), .o_busy(busy),
    .o_wr_en(wr_en), .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_branch(branch),
    .o_branch_target(tgt), .o_carry(carry), .o_break_in_progress(break_in_progress), .o_interrupt_enable_flag(ie),
    .o_delay_slot(slot), .o_mem_we(mem_we), .o_mem_addr(maddr), .o_mem_byte(mbyte),
    .o_link_valid(lvalid), .o_link_data(ldata), .o_link_ctrl(lctrl));
  rsx_far_model u_rsx_far_model (.i_ref_clk(clk), .i_hold(hold), .i_mem_we(mem_we),
    .i_mem_byte(mbyte), .i_link_valid(lvalid), .i_link_data(ldata), .o_link_full(full),
    .o_last_byte(last_byte), .o_last_word(last_word));
  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic stop_test;
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input bit ok, input string m);
    checks++;
    if (!ok)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] rd, input logic [15:0] imm);
    return {op, rd, 5'h00, imm};
  endfunction
  // Wait for the slice to be free, then present one instruction for one edge
  task automatic issue(input logic [31:0] iw, input logic [31:0] va, input logic [31:0] vb, input logic [31:0] vd);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20)
    begin
      tick();
      n++;
    end
    if (n == 20)
    begin
      chk(1'b0, "busy never dropped");
      stop_test();
    end
    instr = iw;
    a = va;
    b = vb;
    d = vd;
    valid = 1'b1;
    tick();
    valid = 1'b0;
  endtask
  // Bounded wait for any result pulse
  task automatic wait_pulse;
    int n;
    n = 0;
    while ((wr_en | branch | mem_we | lvalid) !== 1'b1 && n < 8)
    begin
      tick();
      n++;
    end
    if (n == 8)
    begin
      chk(1'b0, "no result pulse");
      stop_test();
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  // All eight subtract variants, each with two operand pairs that give both borrow outcomes
  task automatic t_sub;
    logic [32:0] s;
    logic [31:0] x, y, iw;
    logic c0, cin;
    for (int i = 0; i < 16; i++)
    begin
      x = i[2] ? 32'h5 : 32'h3;
      y = i[2] ? 32'h3 : 32'h5;
      iw = ins(i[3] ? rsx_pkg::OP_RSUBI : rsx_pkg::OP_RSUB, 5'h07, y[15:0]);
      iw[28] = i[1];
      iw[27] = i[0];
      c0 = carry;
      cin = i[0] ? c0 : 1'b1;
      s = {1'b0, y} + {1'b0, ~x} + 33'(cin);
      issue(iw, x, i[3] ? 32'hdead_0000 : y, 32'h0);
      wait_pulse();
      chk(wr_en === 1'b1 && wr_addr === 5'h07 && wr_data === s[31:0], "subtract result");
      chk(carry === (i[1] ? c0 : s[32]), "subtract carry");
    end
  endtask
  // Interrupt, subroutine and break returns, flags in and after the slot
  task automatic t_ret;
    logic [4:0] rk;
    logic c0;
    for (int k = 0; k < 3; k++)
    begin
      rk = (k == 0) ? rsx_pkg::RET_INT : (k == 1) ? rsx_pkg::RET_SUB : rsx_pkg::RET_BRK;
      c0 = carry;
      issue(ins(rsx_pkg::OP_RET, rk, 16'hfff0), 32'h1000 + 32'h100 * k, 32'h0, 32'h0);
      wait_pulse();
      chk(branch === 1'b1 && slot === 1'b1 && tgt === 32'h0ff0 + 32'h100 * k, "return target");
      chk(ie === (k != 0) && break_in_progress === 1'b0, "flags in slot");
      tick();
      chk(ie === 1'b1 && break_in_progress === 1'b0 && carry === c0, "flags after slot");
    end
  endtask
  // Byte stores: odd unmasked sum, prefixed and plain negative immediates
  task automatic t_store;
    issue(ins(rsx_pkg::OP_SB, 5'h02, 16'h0), 32'h7fff_fffe, 32'h3, 32'habcd_ef5a);
    wait_pulse();
    chk(mem_we === 1'b1 && maddr === 32'h8000_0001 && mbyte === 8'h5a && wr_en === 1'b0, "store reg");
    issue(ins(rsx_pkg::OP_IMM, 5'h00, 16'h1234), 32'h0, 32'h0, 32'h0);
    issue(ins(rsx_pkg::OP_SBI, 5'h02, 16'h8001), 32'h10, 32'h0, 32'h1c3);
    wait_pulse();
    chk(maddr === 32'h1234_8011 && mbyte === 8'hc3, "prefixed store");
    issue(ins(rsx_pkg::OP_SBI, 5'h02, 16'h8001), 32'h10, 32'h0, 32'h77);
    wait_pulse();
    chk(maddr === 32'hffff_8011 && mbyte === 8'h77, "plain store");
    tick();
    chk(last_byte === 8'h77, "memory capture");
  endtask
  // Link writes: refused non-blocking, accepted control word, blocking stall
  task automatic t_put;
    hold = 1'b1;
    issue(ins(rsx_pkg::OP_PUT, 5'h00, 16'h0) | 32'h0001_0000, 32'h11, 32'h0, 32'h0);
    repeat (3)
    begin
      chk(lvalid === 1'b0, "word sent while full");
      tick();
    end
    chk(carry === 1'b1, "full not flagged");
    hold = 1'b0;
    issue(ins(rsx_pkg::OP_PUT, 5'h00, 16'h0) | 32'h0003_0000, 32'h22, 32'h0, 32'h0);
    chk(busy === 1'b1, "second cycle not held");
    wait_pulse();
    chk(ldata === 32'h22 && lctrl === 1'b1 && carry === 1'b0, "control word");
    tick();
    chk(busy === 1'b0, "write longer than two cycles");
    hold = 1'b1;
    issue(ins(rsx_pkg::OP_PUT, 5'h00, 16'h0), 32'h33, 32'h0, 32'h0);
    repeat (4)
    begin
      chk(busy === 1'b1 && lvalid === 1'b0, "no stall");
      tick();
    end
    hold = 1'b0;
    wait_pulse();
    chk(ldata === 32'h33 && lctrl === 1'b0, "stalled word");
    tick();
    chk(last_word === 32'h33, "link capture");
  endtask
  // Reset for five cycles, then run every scenario
  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_sub();
    t_ret();
    t_store();
    t_put();
    stop_test();
  end
endmodule
`default_nettype wire
